// ==== rtl/panel_regs.svh ====
// Purpose: Offsets, field positions, reset values and timing figures
// Assumes: Included by bare name
// Notes:   Definitions only
`ifndef PANEL_REGS_SVH
`define PANEL_REGS_SVH
// ====================================================
// Register offsets
`define OFF_CLOCK_SOURCE   2'h0
`define OFF_SUPPLY_CONTROL 2'h1
`define OFF_BLINK_CONTROL  2'h2
// ====================================================
// Field positions
`define CLK_SOURCE_BIT     7
`define CLK_PRESCALE_BIT   6
`define SUP_PUMP_EN_BIT    7
`define SUP_MULT_BIT       6
`define SUP_HDRV_BIT       3
`define SUP_BYPASS_BIT     2
`define BLK_COMMAND_BIT    7
`define BLK_SCOPE_BIT      3
// ====================================================
// Reset values and masks
`define RST_CLOCK_SOURCE   8'h00
`define RST_SUPPLY_CONTROL 8'h00
`define RST_BLINK_CONTROL  8'h00
`define BLK_WRITE_MASK     8'h8f
// ====================================================
// Timing figures and segment count
`define PRESCALE_LAST      4'hf
`define PUMP_BASE_X2       7'h0c
`define BLINK_EXP_BASE     5
`define SEG_COUNT          164
`endif

// ==== rtl/panel_pkg.sv ====
// Purpose: Types shared by the panel clock, supply and blink block
// Assumes: Nothing imported; users write panel_pkg::name
// Notes:   Struct layouts match the register bit order
package panel_pkg;
  typedef struct packed {
    logic       source_select;
    logic       clock_prescaler_enable;
    logic [5:0] clock_divider_value;
  } clock_cfg_t;

  typedef struct packed {
    logic       charge_pump_enable;
    logic       pump_multiplier_select;
    logic [1:0] pump_clock_adjust;
    logic       high_drive_buffer_select;
    logic       amp_bypass_select;
    logic [1:0] supply_source_select;
  } supply_cfg_t;

  typedef struct packed {
    logic       blink_command;
    logic [2:0] unused;
    logic       blink_scope_select;
    logic [2:0] blink_rate_select;
  } blink_cfg_t;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;
endpackage

// ==== rtl/lcd_clock_supply_blink_ctrl.sv ====
// Purpose: Panel clock divider, pump clock, supply settings and blink control
// Assumes: Single 125 MHz clock; frame start comes from the waveform generator
// Notes:   Bus clock source gives one tick per clock cycle
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
`include "panel_regs.svh"

// Function
// [RULE_01] Bit 7 picks reference or bus clock
// [RULE_02] Bit 6 adds divide-by-16 prescaler
// [RULE_03] Base clock is source over prescale times (n+1)
// [RULE_04] Software leaves clock fields alone while enabled
// [RULE_05] Pump enable forces internal third bias
// [RULE_06] Multiplier bit selects doubler or tripler
// [RULE_07] Pump clock is base over 6*2^(n+1)
// [RULE_08] Bit 3 selects high buffer drive
// [RULE_09] Bit 2 bypasses the op-amp buffer
// [RULE_10] Bits 1:0 choose supply source
// [RULE_11] Software matches supply field to hardware
// [RULE_12] Blink start/stop waits for next frame
// [RULE_13] Scope bit blinks all or enabled segments
// [RULE_14] Blink rate is base over 2^(5+n)
// [RULE_15] Software keeps rate and scope while blinking
// [RULE_16] Segment blinks when enable and on set
// [RULE_17] Blink bits 6:4 read zero; all registers RW
module lcd_clock_supply_blink_ctrl (
  input  wire logic                       clock,                   // 125 MHz
  input  wire logic                       rst_n,                   // Sync reset
  input  wire panel_pkg::reg_req_t        reg_req,                 // Register request
  output logic [7:0]                      reg_rdata,               // Read data, next cycle
  input  wire logic                       external_reference_clock,// Reference pin
  input  wire logic                       display_module_enable,   // Module running
  input  wire logic                       frame_start,             // Frame boundary pulse
  input  wire logic [`SEG_COUNT-1:0]      segment_on,              // On/off bank
  input  wire logic [`SEG_COUNT-1:0]      segment_blink_enable,    // Blink-enable bank
  output logic [`SEG_COUNT-1:0]           segment_drive,           // Segments shown now
  output logic                            panel_base_tick,         // One pulse per base period
  output logic                            pump_clock_tick,         // One pulse per pump period
  output logic                            charge_pump_enable,      // Pump running
  output logic                            internal_third_bias,     // Internal bias forced
  output logic                            pump_multiplier_select,  // 0 doubler, 1 tripler
  output logic                            high_drive_buffer_select,// Enhanced drive
  output logic                            amp_bypass_select,       // Op-amp bypassed
  output logic [1:0]                      supply_source_select,    // Supply source code
  output logic                            blink_active             // Blinking, frame-aligned
);

  // ====================================================
  // Decoding helpers
  function automatic logic [6:0] pump_last(input logic [1:0] adj);
    pump_last = 7'((`PUMP_BASE_X2 << adj) - 7'h01);
  endfunction

  function automatic logic blink_bit(input logic [11:0] cnt, input logic [2:0] rate);
    // Four-bit index: a three-bit sum would wrap for the slowest rates
    blink_bit = cnt[4'(`BLINK_EXP_BASE - 1) + 4'(rate)];
  endfunction

  // ====================================================
  // Register file
  panel_pkg::clock_cfg_t  clk_cfg;
  panel_pkg::clock_cfg_t  next_clk_cfg;
  panel_pkg::supply_cfg_t sup_cfg;
  panel_pkg::supply_cfg_t next_sup_cfg;
  panel_pkg::blink_cfg_t  blk_cfg;
  panel_pkg::blink_cfg_t  next_blk_cfg;
  logic [7:0]             next_rdata;

  always_comb begin
    next_clk_cfg = clk_cfg;
    next_sup_cfg = sup_cfg;
    next_blk_cfg = blk_cfg;
    next_rdata   = 8'h00;
    // Writes accepted at any time; no lock while enabled  (see [RULE_04]) (see [RULE_11])
    if (reg_req.wr) begin
      case (reg_req.addr)
        `OFF_CLOCK_SOURCE:   next_clk_cfg = reg_req.wdata;
        `OFF_SUPPLY_CONTROL: next_sup_cfg = reg_req.wdata;
        `OFF_BLINK_CONTROL:  next_blk_cfg = reg_req.wdata & `BLK_WRITE_MASK; // see [RULE_17]
        default: ;
      endcase
    end
    if (reg_req.rd) begin
      case (reg_req.addr)
        `OFF_CLOCK_SOURCE:   next_rdata = clk_cfg;
        `OFF_SUPPLY_CONTROL: next_rdata = sup_cfg;
        `OFF_BLINK_CONTROL:  next_rdata = blk_cfg; // see [RULE_17]
        default:             next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      clk_cfg   <= `RST_CLOCK_SOURCE;
      sup_cfg   <= `RST_SUPPLY_CONTROL;
      blk_cfg   <= `RST_BLINK_CONTROL;
      reg_rdata <= 8'h00;
    end else begin
      clk_cfg   <= next_clk_cfg;
      sup_cfg   <= next_sup_cfg;
      blk_cfg   <= next_blk_cfg;
      reg_rdata <= next_rdata;
    end
  end

  // Supply settings come straight from the register flops
  assign charge_pump_enable       = sup_cfg.charge_pump_enable;       // see [RULE_05]
  assign internal_third_bias      = sup_cfg.charge_pump_enable;       // see [RULE_05]
  assign pump_multiplier_select   = sup_cfg.pump_multiplier_select;   // see [RULE_06]
  assign high_drive_buffer_select = sup_cfg.high_drive_buffer_select; // see [RULE_08]
  assign amp_bypass_select        = sup_cfg.amp_bypass_select;        // see [RULE_09]
  assign supply_source_select     = sup_cfg.supply_source_select;     // see [RULE_10]

  // ====================================================
  // Reference clock sampling
  // Reference is far slower than the clock, so edge sampling is safe
  logic [2:0] ref_sync;
  logic       ref_level;
  logic       next_ref_level;
  logic       ref_rise;

  always_comb begin
    next_ref_level = ref_level;
    ref_rise       = 1'b0;
    if (ref_sync[1] == ref_sync[2] && ref_sync[2] != ref_level) begin
      next_ref_level = ref_sync[2];
      ref_rise       = ref_sync[2];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ref_sync  <= 3'h0;
      ref_level <= 1'b0;
    end else begin
      ref_sync  <= {ref_sync[1:0], external_reference_clock};
      ref_level <= next_ref_level;
    end
  end

  // ====================================================
  // Clock chain: source, prescaler, divider, pump divider
  logic [3:0] presc_cnt;
  logic [3:0] next_presc_cnt;
  logic [5:0] div_cnt;
  logic [5:0] next_div_cnt;
  logic [6:0] pump_cnt;
  logic [6:0] next_pump_cnt;
  logic       next_base_tick;
  logic       next_pump_tick;
  logic       src_tick;
  logic       pre_tick;

  always_comb begin
    next_presc_cnt = 4'h0;
    next_div_cnt   = div_cnt;
    next_pump_cnt  = pump_cnt;
    next_base_tick = 1'b0;
    next_pump_tick = 1'b0;
    src_tick       = clk_cfg.source_select ? 1'b1 : ref_rise; // see [RULE_01]
    pre_tick       = src_tick;
    if (clk_cfg.clock_prescaler_enable) begin
      pre_tick       = src_tick && (presc_cnt == `PRESCALE_LAST); // see [RULE_02]
      next_presc_cnt = src_tick ? presc_cnt + 4'h1 : presc_cnt;
    end
    if (pre_tick) begin
      // Compare with >= so a shrinking divider value never strands the count
      if (div_cnt >= clk_cfg.clock_divider_value) begin // see [RULE_03]
        next_div_cnt   = 6'h00;
        next_base_tick = 1'b1;
      end else begin
        next_div_cnt = div_cnt + 6'h01;
      end
    end
    if (!sup_cfg.charge_pump_enable) begin
      next_pump_cnt = 7'h00;
    end else if (next_base_tick) begin
      if (pump_cnt >= pump_last(sup_cfg.pump_clock_adjust)) begin // see [RULE_07]
        next_pump_cnt  = 7'h00;
        next_pump_tick = 1'b1;
      end else begin
        next_pump_cnt = pump_cnt + 7'h01;
      end
    end
    if (!display_module_enable) begin
      next_presc_cnt = 4'h0;
      next_div_cnt   = 6'h00;
      next_pump_cnt  = 7'h00;
      next_base_tick = 1'b0;
      next_pump_tick = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      presc_cnt       <= 4'h0;
      div_cnt         <= 6'h00;
      pump_cnt        <= 7'h00;
      panel_base_tick <= 1'b0;
      pump_clock_tick <= 1'b0;
    end else begin
      presc_cnt       <= next_presc_cnt;
      div_cnt         <= next_div_cnt;
      pump_cnt        <= next_pump_cnt;
      panel_base_tick <= next_base_tick;
      pump_clock_tick <= next_pump_tick;
    end
  end

  // ====================================================
  // Blink control
  logic [11:0]           blink_cnt;
  logic [11:0]           next_blink_cnt;
  logic                  next_blink_active;
  logic                  blank_phase;
  logic [`SEG_COUNT-1:0] next_segment_drive;

  always_comb begin
    next_blink_active = blink_active;
    next_blink_cnt    = blink_cnt;
    if (frame_start) begin
      next_blink_active = blk_cfg.blink_command; // see [RULE_12]
    end
    if (!blink_active) begin
      next_blink_cnt = 12'h000;
    end else if (panel_base_tick) begin
      next_blink_cnt = blink_cnt + 12'h001;
    end
    // Second half of each blink period blanks
    blank_phase = blink_active && blink_bit(blink_cnt, blk_cfg.blink_rate_select); // see [RULE_14]
  end

  for (genvar i = 0; i < `SEG_COUNT; i++) begin : g_seg
    always_comb begin
      // Scope 1 blanks all; scope 0 only where both bank bits set
      next_segment_drive[i] = segment_on[i] &&
        !(blank_phase && (blk_cfg.blink_scope_select || segment_blink_enable[i])); // see [RULE_13] (see [RULE_16])
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      blink_active  <= 1'b0;
      blink_cnt     <= 12'h000;
      segment_drive <= '0;
    end else begin
      blink_active  <= next_blink_active;
      blink_cnt     <= next_blink_cnt;
      segment_drive <= next_segment_drive;
    end
  end

endmodule // lcd_clock_supply_blink_ctrl

// ==== tb/panel_sva.sv ====
// Purpose: Port assertions for the panel control block
// Assumes: Synchronous active-low reset
// Notes:   Bound to every instance of the block
`timescale 1ns/1ns
`include "panel_regs.svh"
module panel_sva (
  input wire logic                  clock,                 // Clock
  input wire logic                  rst_n,                 // Reset
  input wire panel_pkg::reg_req_t   reg_req,               // Bus request
  input wire logic [7:0]            reg_rdata,             // Read data
  input wire logic                  display_module_enable, // Enable
  input wire logic                  frame_start,           // Frame pulse
  input wire logic [`SEG_COUNT-1:0] segment_on,            // On bank
  input wire logic [`SEG_COUNT-1:0] segment_drive,         // Shown
  input wire logic                  panel_base_tick,       // Base tick
  input wire logic                  pump_clock_tick,       // Pump tick
  input wire logic                  charge_pump_enable,    // Pump on
  input wire logic                  internal_third_bias,   // Bias
  input wire logic                  blink_active           // Blinking
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // ==========
  // Assertions
  a_rdata_idle: assert property (!reg_req.rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_blink_spare: assert property (reg_req.rd && reg_req.addr == 2'h2 |=> reg_rdata[6:4] == 3'h0)
    else $error("spare blink bits read nonzero");
  a_blink_frame: assert property (!frame_start |=> $stable(blink_active))
    else $error("blink state moved between frames");
  a_bias_forced: assert property (charge_pump_enable == internal_third_bias)
    else $error("bias differs from pump enable");
  a_base_idle: assert property (!display_module_enable [*2] |-> !panel_base_tick)
    else $error("base tick while disabled");
  a_pump_idle: assert property (!charge_pump_enable [*2] |-> !pump_clock_tick)
    else $error("pump tick while pump off");
  a_pump_pulse: assert property (pump_clock_tick |=> !pump_clock_tick)
    else $error("pump tick longer than one cycle");
  a_seg_steady: assert property (!blink_active [*2] |-> segment_drive == $past(segment_on))
    else $error("segments blanked without blinking");
  a_seg_subset: assert property ((segment_drive & ~$past(segment_on)) == '0)
    else $error("segment shown that is off");
  c_blink_on: cover property ($rose(blink_active));
  c_pump_tick: cover property (pump_clock_tick);
  c_spare_read: cover property (reg_req.rd && reg_req.addr == 2'h3);
endmodule // panel_sva
bind lcd_clock_supply_blink_ctrl panel_sva u_panel_sva (.clock, .rst_n, .reg_req, .reg_rdata,
  .display_module_enable, .frame_start, .segment_on, .segment_drive, .panel_base_tick,
  .pump_clock_tick, .charge_pump_enable, .internal_third_bias, .blink_active);

// ==== tb/panel_model.sv ====
// Purpose: Waveform-side stand-in feeding the panel block
// Assumes: Same clock as the block
// Notes:   Reference pin runs free; a frame every 64 cycles
`timescale 1ns/1ns
module panel_model (
  input  wire logic clock,                    // Clock
  input  wire logic rst_n,                    // Reset
  output logic      external_reference_clock, // Free reference
  output logic      frame_start               // Frame pulse
);
  logic [5:0] frame_cnt;
  logic [3:0] ref_cnt;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      frame_cnt <= 6'h00;
      ref_cnt   <= 4'h0;
    end else begin
      frame_cnt <= frame_cnt + 6'h01;
      ref_cnt   <= (ref_cnt == 4'h9) ? 4'h0 : ref_cnt + 4'h1;
    end
  end
  // Ten-clock period keeps tick counts exact
  assign external_reference_clock = (ref_cnt > 4'h4);
  assign frame_start              = (frame_cnt == 6'h3f);
endmodule // panel_model

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the panel control block
// Assumes: Bus clock source ticks every cycle
// Notes:   Clock and supply settings change only while disabled; blink stop writes land while blinking
`timescale 1ns/1ns
`include "panel_regs.svh"
module testbench;
  logic                  clock = 1'b0;
  logic                  rst_n;
  panel_pkg::reg_req_t   reg_req;
  logic [7:0]            reg_rdata, v;
  logic                  external_reference_clock, display_module_enable, frame_start, blink_active;
  logic                  panel_base_tick, pump_clock_tick, charge_pump_enable, internal_third_bias;
  logic                  pump_multiplier_select, high_drive_buffer_select, amp_bypass_select;
  logic [1:0]            supply_source_select;
  logic [`SEG_COUNT-1:0] segment_on, segment_blink_enable, segment_drive, blank;
  int                    n_mismatch = 0;
  int                    compares = 0;
  int                    cycles = 0;
  int                    nb, np, ns, nk;
  logic [7:0]            sups [7] = '{8'hff, 8'h80, 8'h40, 8'h08, 8'h04, 8'h03, 8'h00};
  logic [15:0]           cfg [9] = '{16'h8080, 16'h8090, 16'h80a0, 16'h80b0, 16'h8200,
                                     16'hc100, 16'hc500, 16'h0000, 16'h0100};
  int                    exp_b [9] = '{480, 480, 480, 480, 160, 15, 5, 48, 24};
  int                    exp_p [9] = '{40, 20, 10, 5, 0, 0, 0, 0, 0};
  logic [7:0]            bl [3] = '{8'h80, 8'h81, 8'h88};
  lcd_clock_supply_blink_ctrl u_lcd_clock_supply_blink_ctrl (.clock, .rst_n, .reg_req, .reg_rdata,
    .external_reference_clock, .display_module_enable, .frame_start, .segment_on, .segment_blink_enable,
    .segment_drive, .panel_base_tick, .pump_clock_tick, .charge_pump_enable, .internal_third_bias,
    .pump_multiplier_select, .high_drive_buffer_select, .amp_bypass_select, .supply_source_select,
    .blink_active);
  panel_model u_panel_model (.clock, .rst_n, .external_reference_clock, .frame_start);
  always #4 clock = ~clock;
  // ==========
  // Tasks
  task automatic check(input string what, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    reg_req <= '0;
    @(posedge clock);
  endtask
  // Ends on an edge so the next task drives right after it
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    reg_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
    reg_req <= '0;
    #1 check("rdata", exp, reg_rdata);
    @(posedge clock);
  endtask
  task automatic count(input int n);
    nb = 0;
    np = 0;
    repeat (n) begin
      @(posedge clock);
      #1 nb += panel_base_tick;
      np += pump_clock_tick;
    end
    @(posedge clock);
  endtask
  task automatic wait_frame();
    // Sample off the edge, then end on the edge that takes the pulse
    do @(negedge clock); while (frame_start !== 1'b1);
    @(posedge clock);
  endtask
  task automatic wrap_up();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  // ==========
  // Sequence
  initial begin
    rst_n = 1'b0;
    reg_req = '0;
    display_module_enable = 1'b0;
    segment_on = {41{4'hc}};
    segment_blink_enable = {41{4'ha}};
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 4; i++) rd(i[1:0], 8'h00);
    wr(2'h3, 8'hff);
    rd(2'h3, 8'h00);
    wr(2'h2, 8'hff);
    rd(2'h2, 8'h8f);
    wr(2'h2, 8'h00);
    wr(2'h0, 8'hff);
    rd(2'h0, 8'hff);
    foreach (sups[i]) begin
      v = sups[i];
      wr(2'h1, v);
      rd(2'h1, v);
      #1 check("supply", {v[7], v[7], v[6], v[3], v[2], v[1:0]}, {charge_pump_enable, internal_third_bias,
        pump_multiplier_select, high_drive_buffer_select, amp_bypass_select, supply_source_select});
      @(posedge clock);
    end
    foreach (cfg[i]) begin
      display_module_enable <= 1'b0;
      wr(2'h0, cfg[i][15:8]);
      wr(2'h1, cfg[i][7:0]);
      display_module_enable <= 1'b1;
      repeat (200) @(posedge clock);
      count(480);
      check("base", exp_b[i], nb);
      check("pump", exp_p[i], np);
    end
    display_module_enable <= 1'b0;
    count(480);
    check("idle", 0, nb);
    wr(2'h0, 8'h80);
    display_module_enable <= 1'b1;
    foreach (bl[i]) begin
      wait_frame();
      wr(2'h2, bl[i]);
      repeat (4) @(posedge clock);
      #1 check("early", 1'b0, blink_active);
      wait_frame();
      #1 check("active", 1'b1, blink_active);
      blank = bl[i][3] ? '0 : segment_on & ~segment_blink_enable;
      ns = 0;
      nk = 0;
      repeat (128) begin
        @(posedge clock);
        #1 ns += (segment_drive === segment_on);
        nk += (segment_drive === blank);
      end
      check("shown", 64, ns);
      check("blank", 64, nk);
      @(posedge clock);
      wr(2'h2, 8'h00);
      wait_frame();
      repeat (2) @(posedge clock);
      #1 check("stop", 1'b1, segment_drive === segment_on);
      @(posedge clock);
    end
    wrap_up();
  end
endmodule // testbench
